// >>> core/aps_core.v
// alu status register, indirect pointers and return stack
// assumes the execution logic pulses one operation per cycle
module aps_core
#(
	parameter PC_W = 16
)
(
	input  wire            CLK,
	input  wire            ARST_N,
	input  wire [7:0]      ADDR,
	input  wire [7:0]      WDATA,
	input  wire            WR,
	input  wire            RD,
	output reg  [7:0]      RDATA,
	input  wire            ALU_GO,
	input  wire [2:0]      ALU_OP,
	input  wire [7:0]      ALU_A,
	input  wire [7:0]      ALU_B,
	input  wire            ALU_DEST_STATUS,
	output reg  [7:0]      ALU_RESULT,
	input  wire            IND_ACCESS,
	input  wire            IND_SEL,
	output reg  [7:0]      IND_ADDR,
	input  wire            CALL,
	input  wire            INT_ACK,
	input  wire            RET,
	input  wire [PC_W-1:0] PC_IN,
	output reg  [PC_W-1:0] PC_OUT,
	output reg             PC_LOAD
);
`include "aps_defines.vh"
	// ================================================================
	// signals
	reg  [7:0]      status_reg;
	reg  [7:0]      status_next;
	reg  [7:0]      res;
	reg             c_out;
	reg             dc_out;
	reg             ov_out;
	reg  [8:0]      sum;
	reg  [4:0]      nib;
	reg  [7:0]      b_eff;
	reg             cin;
	wire [7:0]      ptr0;
	wire [7:0]      ptr1;
	wire [PC_W-1:0] top_data;
	wire            room;
	wire            push;
	wire            pop;
	wire            step0;
	wire            step1;
	wire            wr_p0;
	wire            wr_p1;

	// ================================================================
	// alu datapath
	// subtract adds the two's complement so carries become not-borrow
	always @*
	begin
		b_eff  = ALU_B;
		cin    = 1'b0;
		res    = 8'h00;
		c_out  = status_reg[`APS_BIT_CARRY];
		dc_out = status_reg[`APS_BIT_NIBBLE];
		ov_out = status_reg[`APS_BIT_WRAP];
		if (ALU_OP == `APS_OP_SUB)
		begin
			b_eff = ~ALU_B;
			cin   = 1'b1;
		end
		sum = {1'b0, ALU_A} + {1'b0, b_eff} + {8'h00, cin};
		nib = {1'b0, ALU_A[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
		case (ALU_OP)
		`APS_OP_ADD, `APS_OP_SUB:
		begin
			res    = sum[7:0];
			// carry out of the top bit
			c_out  = sum[8];
			// carry out of the fourth bit
			dc_out = nib[4];
			ov_out = (ALU_A[7] == b_eff[7]) && (sum[7] != ALU_A[7]);
		end
		`APS_OP_AND: res = ALU_A & ALU_B;
		`APS_OP_OR:  res = ALU_A | ALU_B;
		`APS_OP_XOR: res = ALU_A ^ ALU_B;
		`APS_OP_RRC:
		begin
			res   = {status_reg[`APS_BIT_CARRY], ALU_A[7:1]};
			c_out = ALU_A[0];
		end
		`APS_OP_RLC:
		begin
			res   = {ALU_A[6:0], status_reg[`APS_BIT_CARRY]};
			c_out = ALU_A[7];
		end
		default: res = ALU_A;
		endcase
	end

	// ================================================================
	// status register update
	// flags from the alu take priority over software data
	always @*
	begin
		status_next = status_reg;
		if (WR && ADDR == `APS_ADDR_STATUS)
			status_next = WDATA;
		if (ALU_GO)
		begin
			if (ALU_DEST_STATUS)
				// store only upper bits, flags own low three
				status_next[7:3] = res[7:3];
			status_next[`APS_BIT_ZERO]   = (res == 8'h00);
			status_next[`APS_BIT_CARRY]  = c_out;
			status_next[`APS_BIT_NIBBLE] = dc_out;
			if (ALU_OP == `APS_OP_ADD || ALU_OP == `APS_OP_SUB)
				status_next[`APS_BIT_WRAP] = ov_out;
		end
	end

	// mode bits come up as ones
	always @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			status_reg <= `APS_STATUS_RESET;
		else
			status_reg <= status_next;
	end

	// ================================================================
	// indirect pointers
	assign step0 = IND_ACCESS && !IND_SEL;
	assign step1 = IND_ACCESS && IND_SEL;
	assign wr_p0 = WR && ADDR == `APS_ADDR_PTR0;
	assign wr_p1 = WR && ADDR == `APS_ADDR_PTR1;

	aps_ptr_step #(.WIDTH(8)) u_ptr0
	(
		.clk     (CLK),
		.arst_n  (ARST_N),
		.wr_en   (wr_p0),
		.wr_data (WDATA),
		.step    (step0),
		.mode    (status_reg[5:4]),
		.ptr_reg (ptr0)
	);

	aps_ptr_step #(.WIDTH(8)) u_ptr1
	(
		.clk     (CLK),
		.arst_n  (ARST_N),
		.wr_en   (wr_p1),
		.wr_data (WDATA),
		.step    (step1),
		.mode    (status_reg[7:6]),
		.ptr_reg (ptr1)
	);

	// ================================================================
	// return stack
	// push on call or vector
	assign push = CALL || INT_ACK;
	assign pop  = RET && !push;

	aps_ret_stack #(.DEPTH(16), .AW(4), .DW(PC_W)) u_stack
	(
		.clk       (CLK),
		.arst_n    (ARST_N),
		.push      (push),
		.pop       (pop),
		.push_data (PC_IN),
		.top_data  (top_data),
		.room_reg  (room)
	);

	// ================================================================
	// registered outputs
	// pc high latch is not touched here, only the pc
	always @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			RDATA      <= 8'h00;
			ALU_RESULT <= 8'h00;
			IND_ADDR   <= 8'h00;
			PC_OUT     <= {PC_W{1'b0}};
			PC_LOAD    <= 1'b0;
		end
		else
		begin
			PC_LOAD <= pop;
			if (pop)
				PC_OUT <= top_data;
			if (ALU_GO)
				ALU_RESULT <= res;
			IND_ADDR <= IND_SEL ? ptr1 : ptr0;
			RDATA <= 8'h00;
			if (RD)
			begin
				case (ADDR)
				`APS_ADDR_STATUS: RDATA <= status_reg;
				`APS_ADDR_PTR0:   RDATA <= ptr0;
				`APS_ADDR_PTR1:   RDATA <= ptr1;
				`APS_ADDR_STACK:  RDATA <= {7'h00, room};
				default:          RDATA <= 8'h00;
				endcase
			end
		end
	end
endmodule // aps_core

// >>> core/aps_defines.vh
// constants for the alu status and call stack block
// assumes a single core clock and an 8-bit register port
// ====================================================================
`ifndef APS_DEFINES_VH
`define APS_DEFINES_VH
// ====================================================================
// register map
`define APS_ADDR_STATUS   8'h04
`define APS_ADDR_PTR0     8'h01
`define APS_ADDR_PTR1     8'h09
`define APS_ADDR_STACK    8'h0c
// ====================================================================
// status field positions and reset value
`define APS_BIT_CARRY     0
`define APS_BIT_NIBBLE    1
`define APS_BIT_ZERO      2
`define APS_BIT_WRAP      3
`define APS_STATUS_RESET  8'hf0
`define APS_PTR_RESET     8'h00
// ====================================================================
// pointer step codes and alu operations
`define APS_STEP_DEC      2'h0
`define APS_STEP_INC      2'h1
`define APS_OP_ADD        3'h0
`define APS_OP_SUB        3'h1
`define APS_OP_AND        3'h2
`define APS_OP_OR         3'h3
`define APS_OP_XOR        3'h4
`define APS_OP_RRC        3'h5
`define APS_OP_RLC        3'h6
`define APS_OP_PASS       3'h7
`endif

// >>> core/aps_ptr_step.v
// one indirect pointer with post-access step by a two-bit mode
// assumes the caller only pulses step on an indirect access
module aps_ptr_step
#(
	parameter WIDTH = 8
)
(
	input  wire             clk,
	input  wire             arst_n,
	input  wire             wr_en,
	input  wire [WIDTH-1:0] wr_data,
	input  wire             step,
	input  wire [1:0]       mode,
	output reg  [WIDTH-1:0] ptr_reg
);
`include "aps_defines.vh"
	reg [WIDTH-1:0] ptr_next;

	// a direct write wins over the post-access step
	always @*
	begin
		ptr_next = ptr_reg;
		if (wr_en)
			ptr_next = wr_data;
		else if (step && mode == `APS_STEP_DEC)
			ptr_next = ptr_reg - {{(WIDTH-1){1'b0}}, 1'b1};
		else if (step && mode == `APS_STEP_INC)
			ptr_next = ptr_reg + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ptr_reg <= `APS_PTR_RESET;
		else
			ptr_reg <= ptr_next;
	end
endmodule // aps_ptr_step

// >>> core/aps_ret_stack.v
// circular return stack with room flag that sticks low after a push at Fh or an early pop
// assumes push and pop never come in the same cycle
module aps_ret_stack
#(
	parameter DEPTH = 16,
	parameter AW    = 4,
	parameter DW    = 16
)
(
	input  wire          clk,
	input  wire          arst_n,
	input  wire          push,
	input  wire          pop,
	input  wire [DW-1:0] push_data,
	output wire [DW-1:0] top_data,
	output reg           room_reg
);
	reg [DW-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] sp_reg;
	reg          lock_reg;
	reg          popped_first_reg;
	reg          seen_op_reg;
	wire [AW-1:0] sp_dec;
	wire [AW-1:0] last_idx;

	assign sp_dec   = sp_reg - {{(AW-1){1'b0}}, 1'b1};
	assign last_idx = {AW{1'b1}};
	// top of stack is the slot just below the stack pointer
	assign top_data = mem[sp_dec];

	// push simply overwrites the oldest slot on wrap
	always @(posedge clk)
	begin
		if (push)
			mem[sp_reg] <= push_data;
	end

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sp_reg           <= {AW{1'b0}};
			room_reg         <= 1'b1;
			lock_reg         <= 1'b0;
			popped_first_reg <= 1'b0;
			seen_op_reg      <= 1'b0;
		end
		else
		begin
			if (push || pop)
				seen_op_reg <= 1'b1;
			if (pop && !seen_op_reg)
				popped_first_reg <= 1'b1;
			if (push)
				sp_reg <= sp_reg + {{(AW-1){1'b0}}, 1'b1};
			else if (pop)
				sp_reg <= sp_dec;
			// early pop then push locks too
			if ((push && sp_reg == last_idx) ||
			    (push && popped_first_reg))
				lock_reg <= 1'b1;
			// clear when pointer lands on Fh
			if (push && sp_reg == last_idx - {{(AW-1){1'b0}}, 1'b1})
				room_reg <= 1'b0;
			else if (pop && sp_reg == {AW{1'b0}})
				room_reg <= 1'b0;
			else if (lock_reg || popped_first_reg)
				room_reg <= 1'b0;
			else if ((push || pop) && sp_reg != last_idx)
				room_reg <= 1'b1;
		end
	end
endmodule // aps_ret_stack

// >>> sim/aps_exec_model.sv
// execution side model: supplies the pc to push, takes popped pc
// assumes pushes and pops are requested by the bench
module aps_exec_model
(
	input  wire        CLK,
	input  wire        ARST_N,
	input  wire        CALL,
	input  wire        INT_ACK,
	input  wire        PC_LOAD,
	input  wire [15:0] PC_OUT,
	output reg  [15:0] PC_IN
);
timeunit 1ns;
timeprecision 1ps;
// ====================================================================
// pc steps per push, reloads on pop
always @(posedge CLK or negedge ARST_N)
begin
	if (!ARST_N)
		PC_IN <= 16'h1000;
	else if (PC_LOAD)
		PC_IN <= PC_OUT;
	else if (CALL || INT_ACK)
		PC_IN <= PC_IN + 16'h0001; // distinct value per push
end
endmodule // aps_exec_model

// >>> sim/aps_monitor.sv
// checker on the status and stack core ports
// assumes one clock and the async active low reset
`include "aps_defines.vh"
module aps_monitor
#(
	parameter PC_W = 16
)
(
	input wire            CLK,
	input wire            ARST_N,
	input wire            RD,
	input wire [7:0]      RDATA,
	input wire            ALU_GO,
	input wire [2:0]      ALU_OP,
	input wire [7:0]      ALU_A,
	input wire [7:0]      ALU_B,
	input wire [7:0]      ALU_RESULT,
	input wire            CALL,
	input wire            INT_ACK,
	input wire            RET,
	input wire [PC_W-1:0] PC_IN,
	input wire [PC_W-1:0] PC_OUT,
	input wire            PC_LOAD
);
timeunit 1ns;
timeprecision 1ps;
// ====================================================================
// properties
default clocking cb @(posedge CLK); endclocking
default disable iff (!ARST_N);
rd_window_a: assert property (!$past(RD) |-> RDATA == 8'h00)
	else $error("read data outside read cycle");
push_pop_a: assert property (CALL ##1 (RET && !CALL && !INT_ACK)
	|=> PC_OUT == $past(PC_IN, 2)) else $error("popped pc wrong");
pop_load_a: assert property (RET && !CALL && !INT_ACK |=> PC_LOAD)
	else $error("pop without load");
load_cause_a: assert property (PC_LOAD |-> $past(RET) &&
	!$past(CALL) && !$past(INT_ACK)) else $error("load without pop");
pc_hold_a: assert property (!PC_LOAD |-> $stable(PC_OUT))
	else $error("pc output moved");
add_sum_a: assert property (ALU_GO && ALU_OP == `APS_OP_ADD
	|=> ALU_RESULT == 8'($past(ALU_A) + $past(ALU_B)))
	else $error("add result wrong");
rrc_shift_a: assert property (ALU_GO && ALU_OP == `APS_OP_RRC
	|=> ALU_RESULT[6:0] == $past(ALU_A[7:1])) else $error("rrc wrong");
rlc_shift_a: assert property (ALU_GO && ALU_OP == `APS_OP_RLC
	|=> ALU_RESULT[7:1] == $past(ALU_A[6:0])) else $error("rlc wrong");
alu_hold_a: assert property (!$past(ALU_GO) |-> $stable(ALU_RESULT))
	else $error("result moved");
cover property (CALL ##1 RET);
cover property (INT_ACK ##1 CALL);
cover property (ALU_GO && ALU_OP == `APS_OP_SUB);
endmodule // aps_monitor
bind aps_core aps_monitor #(.PC_W(PC_W)) i_mon (.CLK(CLK), .ARST_N(ARST_N),
	.RD(RD), .RDATA(RDATA), .ALU_GO(ALU_GO), .ALU_OP(ALU_OP),
	.ALU_A(ALU_A), .ALU_B(ALU_B), .ALU_RESULT(ALU_RESULT), .CALL(CALL),
	.INT_ACK(INT_ACK), .RET(RET), .PC_IN(PC_IN), .PC_OUT(PC_OUT),
	.PC_LOAD(PC_LOAD));

// >>> sim/testbench.sv
// self-checking bench for the status and stack core
// assumes core sources and the execution model are compiled first
module testbench;
timeunit 1ns;
timeprecision 1ps;
logic CLK = 0, ARST_N = 0, WR = 0, RD = 0, ALU_GO = 0, DEST = 0;
logic IND = 0, SEL = 0, CALL = 0, INT_ACK = 0, RET = 0, PC_LOAD;
logic [7:0] ADDR = 0, WDATA = 0, A = 0, B = 0, RDATA, RES, IADDR;
logic [2:0] OP = 0;
logic [15:0] PC_IN, PC_OUT;
int n_tests = 0, n_mismatch = 0;
// op, a, b, result, status after a cleared status
// sub 80-01 wraps below -128 and borrows from the low nibble
logic [35:0] tab [10] = '{36'h0_7f_01_80_0a, 36'h0_ff_01_00_07,
	36'h0_80_80_00_0d, 36'h1_05_05_00_07, 36'h2_f0_0f_00_04,
	36'h5_03_00_01_01, 36'h6_81_00_02_01, 36'h1_80_01_7f_09,
	36'h3_50_0a_5a_00, 36'h4_3c_3c_00_04};
aps_core i_dut (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .ALU_GO(ALU_GO), .ALU_OP(OP),
	.ALU_A(A), .ALU_B(B), .ALU_DEST_STATUS(DEST), .ALU_RESULT(RES),
	.IND_ACCESS(IND), .IND_SEL(SEL), .IND_ADDR(IADDR), .CALL(CALL),
	.INT_ACK(INT_ACK), .RET(RET), .PC_IN(PC_IN), .PC_OUT(PC_OUT),
	.PC_LOAD(PC_LOAD));
aps_exec_model i_exec (.CLK(CLK), .ARST_N(ARST_N), .CALL(CALL),
	.INT_ACK(INT_ACK), .PC_LOAD(PC_LOAD), .PC_OUT(PC_OUT), .PC_IN(PC_IN));
// ====================================================================
// clock and watchdog
initial forever #2.5 CLK = ~CLK;
initial
begin
	#50000;
	n_mismatch++; // run took too long
	finish_test;
end
// ====================================================================
// access tasks; st, alu, pop and ind sample outputs just after the taking edge
task chk(input string what, input logic [15:0] seen, exp);
	n_tests++;
	if (seen !== exp)
	begin
		n_mismatch++;
		$display("[FAIL] %s expected %h seen %h", what, exp, seen);
	end
endtask
task rst;
	@(posedge CLK);
	ARST_N <= 0;
	repeat (8) @(posedge CLK);
	ARST_N <= 1;
endtask
task wr(input logic [7:0] a, d);
	@(posedge CLK);
	WR <= 1;
	ADDR <= a;
	WDATA <= d;
	@(posedge CLK);
	WR <= 0;
endtask
task st(input string w, input logic [7:0] a, e);
	@(posedge CLK);
	RD <= 1;
	ADDR <= a;
	@(posedge CLK);
	RD <= 0;
	#1 chk(w, RDATA, e);
endtask
task alu(input logic [2:0] o, input logic [7:0] a, b, r, input logic d);
	@(posedge CLK);
	{ALU_GO, OP, A, B, DEST} <= {1'b1, o, a, b, d};
	@(posedge CLK);
	{ALU_GO, DEST} <= 2'b00;
	#1 chk("alu result", RES, r);
endtask
task stk(input logic c, i, r);
	@(posedge CLK);
	{CALL, INT_ACK, RET} <= {c, i, r};
	@(posedge CLK);
	{CALL, INT_ACK, RET} <= 3'b000;
endtask
task pop(input logic [15:0] e);
	stk(0, 0, 1);
	#1 chk("pc load", PC_LOAD, 1);
	chk("popped pc", PC_OUT, e);
endtask
task ind(input logic s);
	@(posedge CLK);
	IND <= 1;
	SEL <= s;
	@(posedge CLK);
	IND <= 0;
	#1 chk("indirect address", IADDR, 8'h10);
endtask
task finish_test;
	$display("checks %0d mismatches %0d", n_tests, n_mismatch);
	if (n_mismatch == 0 && n_tests > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
// ====================================================================
// main sequence
initial
begin
	rst;
	st("status reset", 8'h04, 8'hf0);
	st("room reset", 8'h0c, 8'h01);
	// call then return with no gap: the fresh pc comes straight back
	@(posedge CLK);
	CALL <= 1;
	@(posedge CLK);
	{CALL, RET} <= 2'b01;
	@(posedge CLK);
	RET <= 0;
	#1 chk("call then return", PC_OUT, 16'h1000);
	stk(1, 0, 1);
	#1 chk("return beside push", PC_LOAD, 1'b0);
	wr(8'h04, 8'h5a);
	st("status rw", 8'h04, 8'h5a);
	for (int m = 0; m < 4; m++)
		for (int s = 0; s < 2; s++)
		begin
			wr(8'h04, s ? {m[1:0], 6'h00} : {2'h0, m[1:0], 4'h0});
			wr(s ? 8'h09 : 8'h01, 8'h10);
			ind(s[0]);
			st("pointer", s ? 8'h09 : 8'h01,
				m == 0 ? 8'h0f : m == 1 ? 8'h11 : 8'h10);
		end
	foreach (tab[i])
	begin
		wr(8'h04, 8'h00);
		alu(tab[i][34:32], tab[i][31:24], tab[i][23:16], tab[i][15:8], 0);
		st("flags", 8'h04, tab[i][7:0]);
	end
	wr(8'h04, 8'hf3);
	alu(3'h7, 8'h00, 8'h00, 8'h00, 1);
	st("flags into status", 8'h04, 8'h07);
	rst;
	for (int i = 0; i < 17; i++)
	begin
		stk(i[0], !i[0], 0);
		if (i == 13 || i == 14)
			st("room filling", 8'h0c, {7'h0, i == 13});
	end
	st("room wrapped", 8'h0c, 8'h00);
	pop(16'h1010);
	pop(16'h100f);
	st("room locked", 8'h0c, 8'h00);
	rst;
	st("room after reset", 8'h0c, 8'h01);
	stk(0, 0, 1);
	st("room early pop", 8'h0c, 8'h00);
	stk(1, 0, 0);
	stk(0, 0, 1);
	st("room push lock", 8'h0c, 8'h00);
	finish_test;
end
endmodule // testbench
